/* File: design/sdscm_defs.svh */
`ifndef SDSCM_DEFS_SVH
`define SDSCM_DEFS_SVH
// ==========================================
// Mode select encodings
`define SDSCM_MODE_NORMAL 3'h0
`define SDSCM_MODE_PRECHG 3'h1
`define SDSCM_MODE_AREF 3'h2
`define SDSCM_MODE_MRS 3'h3
`define SDSCM_MODE_LDCMD 3'h4
`define SDSCM_MODE_FPROG 3'h5
// ==========================================
// Memory command pins {cs_n, ras_n, cas_n, we_n}
`define SDSCM_CMD_NOP 4'h7
`define SDSCM_CMD_ACT 4'h3
`define SDSCM_CMD_READ 4'h5
`define SDSCM_CMD_WRITE 4'h4
`define SDSCM_CMD_PRE 4'h2
`define SDSCM_CMD_REF 4'h1
`define SDSCM_CMD_MRS 4'h0
// ==========================================
// Flash operation codes on low address byte
`define SDSCM_OP_PROGRAM 8'h40
`define SDSCM_OP_STATUS 8'h70
`define SDSCM_OP_MSB 7
// ==========================================
// Address geometry
`define SDSCM_AP_BIT 10
`define SDSCM_ROW_MUX_HI 10
`define SDSCM_COL_LO_BIT 1
`define SDSCM_BANK_LO_BIT 22
`define SDSCM_ROW_LO_BIT 11
// ==========================================
// Refresh timing, ns per row and cycle counts
`define SDSCM_CLK_PERIOD_NS 4
`define SDSCM_REF_4K_NS 15620
`define SDSCM_REF_8K_NS 7810
`define SDSCM_REF_4K_CYC (`SDSCM_REF_4K_NS / `SDSCM_CLK_PERIOD_NS)
`define SDSCM_REF_8K_CYC (`SDSCM_REF_8K_NS / `SDSCM_CLK_PERIOD_NS)
`define SDSCM_REF_4K_ROWS 13'h1000
`define SDSCM_REF_8K_ROWS 14'h2000
`define SDSCM_STAT_LSB 0
`define SDSCM_CL_MIN 2'h1
`endif

/* File: design/sdscm_pkg.sv */
package sdscm_pkg;
  // Memory-side command word with address
  typedef struct packed {
    logic [3:0] cmd;
    logic [1:0] bank;
    logic [12:0] addr;
  } sdscm_mem_cmd_t;

  // Bus request
  typedef struct packed {
    logic write;
    logic [23:0] addr;
    logic [31:0] wdata;
  } sdscm_bus_req_t;
endpackage

/* File: design/sdscm_refresh_timer.sv */
`timescale 1ns/10ps
`include "sdscm_defs.svh"
module sdscm_refresh_timer
  import sdscm_pkg::*;
(
  input wire logic clk_in,
  input wire logic resetn_in,
  input wire logic dense_in,
  input wire logic done_in,
  output logic due_out
);
  logic [12:0] cnt_q;
  logic [12:0] cnt_d;
  logic due_q;
  logic due_d;

  // ==========================================
  // Per-row interval, 4096 or 8192 row devices
  always_comb begin
    cnt_d = cnt_q;
    due_d = due_q;
    if (done_in) begin
      due_d = 1'b0;
    end
    if (cnt_q == 13'h0) begin
      cnt_d = dense_in ? 13'(`SDSCM_REF_8K_CYC - 1) : 13'(`SDSCM_REF_4K_CYC - 1);
      due_d = 1'b1;
    end else begin
      cnt_d = cnt_q - 13'h1;
    end
  end

  always_ff @(posedge clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      cnt_q <= 13'h0;
      due_q <= 1'b0;
    end else begin
      cnt_q <= cnt_d;
      due_q <= due_d;
    end
  end

  assign due_out = due_q;
endmodule

/* File: design/sdscm_ctrl.sv */
`timescale 1ns/10ps
`include "sdscm_defs.svh"
// Operation
// - Mode 011 makes every memory access a mode-register-set with value on address.
// - Read or write triggers mode set; write data dropped, data bus undriven.
// - Mode value appears on row and bank address outputs.
// - Mode set access takes two bus clocks, command lasts one clock.
// - Flash triplet order: load command, activate, read or write; gaps allowed.
// - Load command uses the refresh command pin encoding.
// - Load-command mode: any access issues load command, opcode from address.
// - Program write: load command with low byte 0x40, bank and address kept.
// - Then activate with row and bank, write with column, bank, data.
// - No burst terminate after flash program write.
// - Program-mode read: load 0x70, activate, read with bank and column.
// - Status captured from low eight data lines after column latency.
// - Any width or density with four banks on two bank bits.
// - Refresh 4096 rows at one row per 15.62 us, or 8192 rows at one row per 7.81 us.
// - Only row/column differing lines multiplexed; upper row and bank steady.
// - Precharge mode: address line ten high precharges all, else one bank.
module sdscm_ctrl
  import sdscm_pkg::*;
(
  input wire logic clk_in,
  input wire logic resetn_in,
  input wire logic [2:0] command_mode_select_in,
  input wire logic dense_in,
  input wire logic [1:0] column_latency_in,
  input wire logic req_valid_in,
  input wire sdscm_bus_req_t req_in,
  output logic req_ready_out,
  output logic resp_valid_out,
  output logic [31:0] resp_rdata_out,
  output logic memory_chip_select_n_out,
  output logic ras_n_out,
  output logic cas_n_out,
  output logic memory_write_strobe_n_out,
  output logic [1:0] bank_out,
  output logic [12:0] addr_out,
  output logic [31:0] dq_out,
  output logic dq_oe_out,
  input wire logic [31:0] dq_in,
  output logic refresh_due_out
);
  typedef enum logic [3:0] {
    S_IDLE, S_FIN, S_ACT, S_ACC, S_LAT, S_DONE
  } sdscm_state_t;

  sdscm_state_t st_q, st_d;
  sdscm_bus_req_t req_q, req_d;
  sdscm_mem_cmd_t mc_q, mc_d;
  logic [31:0] dq_q, dq_d;
  logic oe_q, oe_d;
  logic rdy_q, rdy_d;
  logic rv_q, rv_d;
  logic [31:0] rd_q, rd_d;
  logic [1:0] lat_q, lat_d;
  logic ref_due;
  logic ref_done_q, ref_done_d;
  logic [2:0] mode_q, mode_d;
  logic take;

  // Mode is sampled with the request, a later change cannot split a sequence
  assign take = req_valid_in && rdy_q;

  // ==========================================
  // Address helpers
  function automatic logic [1:0] bank_of(input logic [23:0] a);
    return a[`SDSCM_BANK_LO_BIT +: 2];
  endfunction

  // Upper row bits above the fold stay on their pins in both phases
  function automatic logic [12:0] row_of(input logic [23:0] a);
    return a[`SDSCM_ROW_LO_BIT +: 13];
  endfunction

  function automatic logic [12:0] col_of(input logic [23:0] a);
    logic [12:0] r;
    r = row_of(a);
    r[`SDSCM_ROW_MUX_HI:0] = a[`SDSCM_COL_LO_BIT +: 11];
    r[`SDSCM_AP_BIT] = 1'b0;
    return r;
  endfunction

  // Opcode takes the low address byte, the rest still names the target
  function automatic logic [12:0] ld_addr_of(input logic [23:0] a, input logic [7:0] op);
    logic [12:0] r;
    r = row_of(a);
    r[`SDSCM_OP_MSB:0] = op;
    return r;
  endfunction

  function automatic sdscm_mem_cmd_t mk(input logic [3:0] c, input logic [1:0] b,
                                        input logic [12:0] a);
    sdscm_mem_cmd_t m;
    m.cmd = c;
    m.bank = b;
    m.addr = a;
    return m;
  endfunction

  // ==========================================
  // Refresh interval timer
  sdscm_refresh_timer u_ref (
    .clk_in(clk_in),
    .resetn_in(resetn_in),
    .dense_in(dense_in),
    .done_in(ref_done_q),
    .due_out(ref_due)
  );

  // ==========================================
  // Command sequencer
  always_comb begin
    st_d = st_q;
    req_d = req_q;
    mode_d = mode_q;
    mc_d = mk(`SDSCM_CMD_NOP, mc_q.bank, mc_q.addr);
    rdy_d = 1'b0;
    case (st_q)
      S_IDLE: begin
        rdy_d = 1'b1;
        if (take) begin
          req_d = req_in;
          mode_d = command_mode_select_in;
          rdy_d = 1'b0;
          // Special modes other than flash program end after one command, never touching the array
          st_d = S_FIN;
          case (command_mode_select_in)
            `SDSCM_MODE_MRS: begin
              // Row and bank lines carry the value, data stays off the pins
              mc_d = mk(`SDSCM_CMD_MRS, bank_of(req_in.addr), row_of(req_in.addr));
            end
            `SDSCM_MODE_PRECHG: begin
              mc_d = mk(`SDSCM_CMD_PRE, bank_of(req_in.addr), row_of(req_in.addr));
            end
            `SDSCM_MODE_AREF: begin
              mc_d = mk(`SDSCM_CMD_REF, bank_of(req_in.addr), row_of(req_in.addr));
            end
            `SDSCM_MODE_LDCMD: begin
              mc_d = mk(`SDSCM_CMD_REF, bank_of(req_in.addr), row_of(req_in.addr));
            end
            `SDSCM_MODE_FPROG: begin
              // Hardware triplet, opcode forced on the low address byte
              mc_d = mk(`SDSCM_CMD_REF, bank_of(req_in.addr),
                        ld_addr_of(req_in.addr, req_in.write ? `SDSCM_OP_PROGRAM
                                                             : `SDSCM_OP_STATUS));
              st_d = S_ACT;
            end
            default: begin
              // Normal array access, activate then column access
              mc_d = mk(`SDSCM_CMD_ACT, bank_of(req_in.addr), row_of(req_in.addr));
              st_d = S_ACC;
            end
          endcase
        end
      end
      S_ACT: begin
        mc_d = mk(`SDSCM_CMD_ACT, bank_of(req_q.addr), row_of(req_q.addr));
        st_d = S_ACC;
      end
      S_ACC: begin
        if (req_q.write) begin
          mc_d = mk(`SDSCM_CMD_WRITE, bank_of(req_q.addr), col_of(req_q.addr));
          // Flash takes single writes, so no burst terminate follows
          st_d = S_FIN;
        end else begin
          mc_d = mk(`SDSCM_CMD_READ, bank_of(req_q.addr), col_of(req_q.addr));
          st_d = S_LAT;
        end
      end
      S_LAT: begin
        if (lat_q <= `SDSCM_CL_MIN) begin
          st_d = S_DONE;
        end
      end
      S_DONE: begin
        st_d = S_IDLE;
      end
      S_FIN: begin
        st_d = S_IDLE;
      end
      default: begin
        st_d = S_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      st_q <= S_IDLE;
      req_q <= '0;
      mode_q <= `SDSCM_MODE_NORMAL;
      mc_q <= '{cmd: `SDSCM_CMD_NOP, bank: 2'h0, addr: 13'h0};
      rdy_q <= 1'b0;
    end else begin
      st_q <= st_d;
      req_q <= req_d;
      mode_q <= mode_d;
      mc_q <= mc_d;
      rdy_q <= rdy_d;
    end
  end

  // ==========================================
  // Column latency counter
  always_comb begin
    lat_d = lat_q;
    if (st_q == S_ACC && !req_q.write) begin
      lat_d = column_latency_in;
    end else if (st_q == S_LAT && lat_q > `SDSCM_CL_MIN) begin
      lat_d = lat_q - 2'h1;
    end
  end

  always_ff @(posedge clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      lat_q <= 2'h0;
    end else begin
      lat_q <= lat_d;
    end
  end

  // ==========================================
  // Write data drive, only in the column slot of a write
  // Mode set and load command never reach this slot, so the bus stays off
  always_comb begin
    dq_d = dq_q;
    oe_d = 1'b0;
    if (st_q == S_ACC && req_q.write) begin
      dq_d = req_q.wdata;
      oe_d = 1'b1;
    end
  end

  always_ff @(posedge clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      dq_q <= 32'h0;
      oe_q <= 1'b0;
    end else begin
      dq_q <= dq_d;
      oe_q <= oe_d;
    end
  end

  // ==========================================
  // Response, status reads keep only the low data byte
  always_comb begin
    rv_d = 1'b0;
    rd_d = rd_q;
    if (st_q == S_DONE) begin
      rv_d = 1'b1;
      if (mode_q == `SDSCM_MODE_FPROG) begin
        rd_d = {24'h0, dq_in[`SDSCM_STAT_LSB +: 8]};
      end else begin
        rd_d = dq_in;
      end
    end else if (st_q == S_FIN) begin
      rv_d = 1'b1;
      rd_d = 32'h0;
    end
  end

  always_ff @(posedge clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      rv_q <= 1'b0;
      rd_q <= 32'h0;
    end else begin
      rv_q <= rv_d;
      rd_q <= rd_d;
    end
  end

  // ==========================================
  // Software refresh clears the due flag one clock after acceptance
  always_comb begin
    ref_done_d = 1'b0;
    if (take && command_mode_select_in == `SDSCM_MODE_AREF) begin
      ref_done_d = 1'b1;
    end
  end

  always_ff @(posedge clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      ref_done_q <= 1'b0;
    end else begin
      ref_done_q <= ref_done_d;
    end
  end

  // ==========================================
  // Outputs, all from flops
  assign req_ready_out = rdy_q;
  assign resp_valid_out = rv_q;
  assign resp_rdata_out = rd_q;
  assign memory_chip_select_n_out = mc_q.cmd[3];
  assign ras_n_out = mc_q.cmd[2];
  assign cas_n_out = mc_q.cmd[1];
  assign memory_write_strobe_n_out = mc_q.cmd[0];
  assign bank_out = mc_q.bank;
  assign addr_out = mc_q.addr;
  assign dq_out = dq_q;
  assign dq_oe_out = oe_q;
  assign refresh_due_out = ref_due;
endmodule

/* File: dv/sdscm_ctrl_properties.sv */
`timescale 1ns/10ps
`include "sdscm_defs.svh"
// ==========
// Pin checker
module sdscm_ctrl_properties
  import sdscm_pkg::*;
(
  input wire logic clk_in,
  input wire logic resetn_in,
  input wire logic [2:0] command_mode_select_in,
  input wire logic req_valid_in,
  input wire sdscm_bus_req_t req_in,
  input wire logic req_ready_out,
  input wire logic resp_valid_out,
  input wire logic memory_chip_select_n_out,
  input wire logic ras_n_out,
  input wire logic cas_n_out,
  input wire logic memory_write_strobe_n_out,
  input wire logic [1:0] bank_out,
  input wire logic [12:0] addr_out,
  input wire logic dq_oe_out
);
  wire [3:0] cmd = {memory_chip_select_n_out, ras_n_out, cas_n_out, memory_write_strobe_n_out};
  wire acc = req_valid_in && req_ready_out;
  wire [2:0] m = command_mode_select_in;
  wire fp = acc && m == `SDSCM_MODE_FPROG;
  default clocking @(posedge clk_in); endclocking
  default disable iff (!resetn_in);
  property p_mrs; acc && m == `SDSCM_MODE_MRS |=> cmd == `SDSCM_CMD_MRS &&
    {bank_out, addr_out} == $past({req_in.addr[23:22], req_in.addr[23:11]}); endproperty
  property p_len; acc && m == `SDSCM_MODE_MRS |=> ##1 cmd == `SDSCM_CMD_NOP && resp_valid_out;
  endproperty
  property p_oe; acc && m == `SDSCM_MODE_MRS |=> (!dq_oe_out)[*2]; endproperty
  property p_ld; acc && m == `SDSCM_MODE_LDCMD |=> cmd == `SDSCM_CMD_REF; endproperty
  property p_pw; fp && req_in.write |=> cmd == `SDSCM_CMD_REF && addr_out[7:0] == 8'h40
    ##1 cmd == `SDSCM_CMD_ACT && $stable(bank_out)
    ##1 cmd == `SDSCM_CMD_WRITE && dq_oe_out && $stable(bank_out); endproperty
  property p_pr; fp && !req_in.write |=> cmd == `SDSCM_CMD_REF && addr_out[7:0] == 8'h70
    ##1 cmd == `SDSCM_CMD_ACT ##1 cmd == `SDSCM_CMD_READ && $stable(bank_out); endproperty
  property p_pre; acc && m == `SDSCM_MODE_PRECHG |=> cmd == `SDSCM_CMD_PRE &&
    addr_out[10] == $past(req_in.addr[21]); endproperty
  // Burst terminate pins are low, low-high-high-low
  property p_nobt; cmd != 4'h6; endproperty
  property p_noarr; acc && m != 3'h0 && m < 3'h5 |=>
    (cmd != `SDSCM_CMD_READ && cmd != `SDSCM_CMD_WRITE)[*3]; endproperty
  a_mrs: assert property (p_mrs) else $error("mode set pins wrong");
  a_len: assert property (p_len) else $error("mode set length wrong");
  a_oe: assert property (p_oe) else $error("data bus driven in mode set");
  a_ld: assert property (p_ld) else $error("load command code wrong");
  a_pw: assert property (p_pw) else $error("program triplet wrong");
  a_pr: assert property (p_pr) else $error("status triplet wrong");
  a_pre: assert property (p_pre) else $error("precharge wrong");
  a_nobt: assert property (p_nobt) else $error("burst terminate seen");
  a_noarr: assert property (p_noarr) else $error("array access in special mode");
  c_mrs: cover property (acc && m == `SDSCM_MODE_MRS);
  c_pw: cover property (fp && req_in.write);
  c_pr: cover property (fp && !req_in.write);
endmodule
bind sdscm_ctrl sdscm_ctrl_properties u_props (.clk_in(clk_in), .resetn_in(resetn_in),
  .command_mode_select_in(command_mode_select_in), .req_valid_in(req_valid_in),
  .req_in(req_in), .req_ready_out(req_ready_out), .resp_valid_out(resp_valid_out),
  .memory_chip_select_n_out(memory_chip_select_n_out), .ras_n_out(ras_n_out),
  .cas_n_out(cas_n_out), .memory_write_strobe_n_out(memory_write_strobe_n_out),
  .bank_out(bank_out), .addr_out(addr_out), .dq_oe_out(dq_oe_out));

/* File: dv/sdscm_mem_model.sv */
`timescale 1ns/10ps
`include "sdscm_defs.svh"
// ==========
// Flash status responder
module sdscm_mem_model (
  input wire logic clk_in,
  input wire logic [3:0] cmd_in,
  input wire logic [1:0] column_latency_in,
  input wire logic [7:0] status_in,
  output logic [31:0] dq_out
);
  int cnt = 7;
  int nc;
  initial dq_out = 32'h0;
  // Status stands only in the slot the latency names, so an early or late capture misses
  always @(posedge clk_in) begin
    nc = (cmd_in == `SDSCM_CMD_READ) ? 1 : ((cnt < 7) ? cnt + 1 : 7);
    cnt <= nc;
    dq_out <= (nc == int'(column_latency_in)) ? {~dq_out[31:8], status_in}
                                             : {~dq_out[31:8], ~status_in};
  end
endmodule

/* File: dv/sdram_special_command_modes_bench.sv */
`timescale 1ns/10ps
`include "sdscm_defs.svh"
// ==========
// Bench
module sdram_special_command_modes_bench import sdscm_pkg::*; ;
  logic clk_in = 1'b0;
  logic resetn_in = 1'b0;
  logic [2:0] mode = 3'h0;
  logic [1:0] lat = 2'h2;
  logic valid = 1'b0;
  sdscm_bus_req_t req = '0;
  logic ready, rv, cs_n, ras_n, cas_n, we_n, oe, due;
  logic [31:0] rdata, dq_o, dq_i, got;
  logic [1:0] bank;
  logic [12:0] addr;
  logic [7:0] stat = 8'h00;
  logic dense = 1'b1;
  int cyc = 0;
  logic [31:0] wd;
  int bad_count = 0;
  int n_checks = 0;
  sdscm_mem_cmd_t q[$];
  wire [3:0] cmd = {cs_n, ras_n, cas_n, we_n};
  sdscm_ctrl DUT (.clk_in(clk_in), .resetn_in(resetn_in), .command_mode_select_in(mode),
    .dense_in(dense), .column_latency_in(lat), .req_valid_in(valid), .req_in(req),
    .req_ready_out(ready), .resp_valid_out(rv), .resp_rdata_out(rdata),
    .memory_chip_select_n_out(cs_n), .ras_n_out(ras_n), .cas_n_out(cas_n),
    .memory_write_strobe_n_out(we_n), .bank_out(bank), .addr_out(addr), .dq_out(dq_o),
    .dq_oe_out(oe), .dq_in(dq_i), .refresh_due_out(due));
  sdscm_mem_model u_mem (.clk_in(clk_in), .cmd_in(cmd), .column_latency_in(lat),
    .status_in(stat), .dq_out(dq_i));
  initial forever #2 clk_in = ~clk_in;
  always @(posedge clk_in) if (cmd != `SDSCM_CMD_NOP) q.push_back('{cmd, bank, addr});
  always @(posedge clk_in) cyc <= cyc + 1;
  always @(posedge clk_in) if (oe) wd <= dq_o;
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    n_checks++;
    if (g !== e) begin
      bad_count++;
      $display("FAIL t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask
  task automatic acc(input logic [2:0] md, input logic wr, input logic [23:0] a);
    int i;
    q.delete();
    mode = md;
    req = '{wr, a, 32'ha5c3_0f96};
    valid = 1'b1;
    for (i = 0; i < 40 && ready !== 1'b1; i++) @(posedge clk_in) #1;
    @(posedge clk_in) #1;
    valid = 1'b0;
    for (i = 0; i < 40 && rv !== 1'b1; i++) @(posedge clk_in) #1;
    got = rdata;
    @(posedge clk_in) #1;
  endtask
  task automatic t_due();
    int n;
    int c0;
    for (n = 0; n < 5000 && due !== 1'b1; n++) @(posedge clk_in) #1;
    c0 = cyc;
    dense = 1'b0;
    acc(`SDSCM_MODE_AREF, 1'b1, 24'h0);
    chk(due, 1'b0);
    for (n = 0; n < 5000 && due !== 1'b1; n++) @(posedge clk_in) #1;
    chk(cyc - c0, `SDSCM_REF_8K_CYC);
    c0 = cyc;
    acc(`SDSCM_MODE_AREF, 1'b0, 24'h0);
    chk(due, 1'b0);
    for (n = 0; n < 5000 && due !== 1'b1; n++) @(posedge clk_in) #1;
    chk(cyc - c0, `SDSCM_REF_4K_CYC);
    dense = 1'b1;
  endtask
  task automatic t_pre();
    acc(`SDSCM_MODE_PRECHG, 1'b0, 24'h80_0000);
    chk({q[0].cmd, q[0].bank, q[0].addr[10]}, {`SDSCM_CMD_PRE, 2'h2, 1'b0});
    acc(`SDSCM_MODE_PRECHG, 1'b1, 24'h20_0000);
    chk({q[0].cmd, q[0].addr[10]}, {`SDSCM_CMD_PRE, 1'b1});
  endtask
  task automatic t_mrs();
    logic [23:0] a;
    for (int b = 0; b < 8; b++) begin
      a = {b[1:0], 22'h0a_5800};
      repeat (10) @(posedge clk_in) #1;
      acc(`SDSCM_MODE_MRS, b[2], a);
      chk(q.size(), 1);
      chk(32'(q[0]), {`SDSCM_CMD_MRS, a[23:22], a[23:11]});
    end
  endtask
  task automatic t_ld();
    acc(`SDSCM_MODE_LDCMD, 1'b0, 24'h40_1234);
    chk({q[0].cmd, q[0].bank}, {`SDSCM_CMD_REF, 2'h1});
    acc(`SDSCM_MODE_NORMAL, 1'b0, 24'h40_2000);
  endtask
  task automatic t_fw();
    acc(`SDSCM_MODE_FPROG, 1'b1, 24'hc3_a56e);
    chk(q.size(), 3);
    chk({q[0].cmd, q[0].bank, q[0].addr[7:0]}, {`SDSCM_CMD_REF, 2'h3, 8'h40});
    chk(32'(q[1]), {`SDSCM_CMD_ACT, 2'h3, 13'h1874});
    chk({q[2].cmd, q[2].bank}, {`SDSCM_CMD_WRITE, 2'h3});
    chk(q[2].addr, 13'h1ab7);
    chk(wd, 32'ha5c3_0f96);
  endtask
  task automatic t_fr();
    for (int l = 1; l < 4; l++) begin
      lat = 2'(l);
      stat = 8'h5a ^ 8'(l);
      acc(`SDSCM_MODE_FPROG, 1'b0, 24'h41_0203);
      chk({q[0].cmd, q[0].addr[7:0]}, {`SDSCM_CMD_REF, 8'h70});
      chk({q[2].cmd, q[2].bank}, {`SDSCM_CMD_READ, 2'h1});
      chk(got, {24'h0, stat});
    end
  endtask
  task automatic print_verdict();
    $display("checks %0d mismatches %0d", n_checks, bad_count);
    if (bad_count == 0 && n_checks > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  initial begin
    repeat (8) @(posedge clk_in);
    #1;
    chk({cmd, oe}, {`SDSCM_CMD_NOP, 1'b0});
    resetn_in = 1'b1;
    t_due();
    t_pre();
    t_mrs();
    t_ld();
    t_fw();
    t_fr();
    print_verdict();
  end
  // Whole run is near 6000 cycles, so 10000 means a hang
  initial begin
    #40000;
    bad_count++;
    print_verdict();
  end
endmodule
